//--- shared/fault_readback_map.svh
// Offsets, field positions, reset values and codes of the status readback bank
`ifndef FAULT_READBACK_MAP_SVH
`define FAULT_READBACK_MAP_SVH
`define WORD_W 16
`define FRAME_BITS 5'h10
`define ADDR_INIT 4'h0
`define ADDR_QUICK 4'h1
`define ADDR_CH1 4'h2
`define ADDR_CHIP 4'h7
`define ADDR_PINS 4'h8
`define ADDR_IDENT 4'h9
`define SEL_DEFAULT 4'h0
`define SI_ADDR_MSB 15
`define SI_ADDR_LSB 12
`define SI_PERSIST_POS 4
`define SI_SEL_MSB 3
`define SI_SEL_LSB 0
`define FM_POS 11
`define RCF_RESET 1'b1
`define PERSIST_RESET 1'b0
`define OC_NONE 3'h0
`endif

//--- shared/fault_readback_pkg.sv
// Types of the status readback bank
package fault_readback_pkg;
    typedef enum logic [1:0] {
        FR_IDLE = 2'h0,
        FR_SHIFT = 2'h1,
        FR_DONE = 2'h3
    } frame_state_t;
    typedef enum logic [2:0] {
        OC_NONE_T = 3'h0,
        OC_FIRST_T = 3'h1,
        OC_SECOND_T = 3'h2,
        OC_THIRD_T = 3'h3,
        OC_STEADY_T = 3'h4,
        OC_NOWIN_T = 3'h5,
        OC_SEVERE_T = 3'h6
    } oc_code_t;
endpackage

//--- verilog/spi_fault_status_readback.sv
// Serial status readback bank: word selection, fault latching and shift-out
`timescale 1ns/1ps
`default_nettype none
`include "fault_readback_map.svh"

module spi_fault_status_readback #(
    parameter int CHANNELS = 5,
    parameter logic [7:0] PART_CODE = 8'h5A // Value is arbitrary
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial port pins
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    output logic spi_so,
    output logic spi_so_oe,
    // Channel fault events
    input wire logic [4:0] overheat_shutdown,
    input wire logic [4:0] overheat_warning,
    input wire logic [4:0] overcurrent_event,
    input wire logic [14:0] overcurrent_code,
    input wire logic [4:0] open_load_on_flag,
    input wire logic [4:0] open_load_off_flag,
    // Device fault events and mode
    input wire logic pump_fault,
    input wire logic pwm_clock_fault,
    input wire logic supply_low_flag,
    input wire logic supply_high_flag,
    input wire logic factory_test_flag,
    input wire logic serial_fail_flag,
    input wire logic failsafe_active,
    // Real-time levels
    input wire logic limp_input_level,
    input wire logic [3:0] control_input_level,
    input wire logic [3:0] input_toggle,
    input wire logic [4:0] load_pin_high,
    // Readback setting
    output logic [3:0] readback_select,
    output logic readback_persist_sel
);

    if (CHANNELS != 5) begin : g_bad_channels
        $error("Word layout serves exactly five channels");
    end

    // True when the selector addresses channel n
    function automatic logic is_chan(input logic [3:0] sel, input int n);
        is_chan = (sel == 4'(`ADDR_CH1 + n));
    endfunction

    // Pin synchronisers, first stage read only by second
    logic [2:0] s1_q, s2_q, s1_d, s2_d;
    logic sclk_old_q, cs_old_q, sclk_old_d, cs_old_d;
    always_comb begin
        s1_d = {spi_clk, spi_cs_n, spi_si};
        s2_d = s1_q;
        sclk_old_d = s2_q[2];
        cs_old_d = s2_q[1];
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Idle pin levels (clock low, select high) so no false edge follows reset
            s1_q <= 3'h2;
            s2_q <= 3'h2;
            sclk_old_q <= 1'b0;
            cs_old_q <= 1'b1;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            sclk_old_q <= sclk_old_d;
            cs_old_q <= cs_old_d;
        end
    end

    logic sclk_rise, sclk_fall, cs_fall, cs_rise;
    assign sclk_rise = s2_q[2] & ~sclk_old_q;
    assign sclk_fall = ~s2_q[2] & sclk_old_q;
    assign cs_fall = ~s2_q[1] & cs_old_q;
    assign cs_rise = s2_q[1] & ~cs_old_q;

    // Latched fault state
    logic [6:0] ch_q [CHANNELS];
    logic pump_q, pwm_clock_fault_q, uv_q, ov_q, tm_q, serial_fail_flag_q, rcf_q;
    logic [CHANNELS-1:0] chan_clr;
    logic chip_clr, frame_ok, frame_bad;
    logic [3:0] sent_sel_q;

    // Summary flags follow the latched detail bits
    logic overload_summary, open_load_summary, chip_summary_flag;
    logic [CHANNELS-1:0] chan_quick_flag, ovl_ch, ol_ch;
    for (genvar i = 0; i < CHANNELS; i++) begin : g_sum
        assign chan_quick_flag[i] = |ch_q[i];
        assign ovl_ch[i] = ch_q[i][6] | (ch_q[i][4:2] != `OC_NONE);
        assign ol_ch[i] = ch_q[i][1] | ch_q[i][0];
    end
    assign overload_summary = |ovl_ch;
    assign open_load_summary = |ol_ch;
    assign chip_summary_flag = rcf_q | uv_q | ov_q | pump_q | pwm_clock_fault_q | tm_q;

    // Channel fault latches; a new event beats a read clear
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        logic [6:0] d;
        always_comb begin
            d = chan_clr[i] ? 7'h00 : ch_q[i];
            if (overcurrent_event[i]) begin
                d[4:2] = overcurrent_code[3*i +: 3];
            end
            d[6] = d[6] | overheat_shutdown[i];
            d[5] = d[5] | overheat_warning[i];
            d[1] = d[1] | open_load_on_flag[i];
            d[0] = d[0] | open_load_off_flag[i];
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                ch_q[i] <= 7'h00;
            end else begin
                ch_q[i] <= d;
            end
        end
    end

    // Device fault latches, cleared by reading the chip word
    logic pump_d, pwm_clock_fault_d, uv_d, ov_d, tm_d, serial_fail_flag_d, rcf_d;
    always_comb begin
        pump_d = (pump_q & ~chip_clr) | pump_fault;
        pwm_clock_fault_d = (pwm_clock_fault_q & ~chip_clr) | pwm_clock_fault;
        uv_d = (uv_q & ~chip_clr) | supply_low_flag;
        ov_d = (ov_q & ~chip_clr) | supply_high_flag;
        tm_d = (tm_q & ~chip_clr) | factory_test_flag;
        serial_fail_flag_d = (serial_fail_flag_q & ~chip_clr) | serial_fail_flag | frame_bad;
        rcf_d = rcf_q & ~chip_clr;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pump_q <= 1'b0;
            pwm_clock_fault_q <= 1'b0;
            uv_q <= 1'b0;
            ov_q <= 1'b0;
            tm_q <= 1'b0;
            serial_fail_flag_q <= 1'b0;
            rcf_q <= `RCF_RESET;
        end else begin
            pump_q <= pump_d;
            pwm_clock_fault_q <= pwm_clock_fault_d;
            uv_q <= uv_d;
            ov_q <= ov_d;
            tm_q <= tm_d;
            serial_fail_flag_q <= serial_fail_flag_d;
            rcf_q <= rcf_d;
        end
    end

    // Assemble the word picked by the selector
    logic [15:0] word;
    logic [2:0] sums;
    always_comb begin
        sums = {chip_summary_flag, overload_summary, open_load_summary};
        word = {`ADDR_QUICK, failsafe_active, sums, pump_q, rcf_q, pwm_clock_fault_q,
                chan_quick_flag};
        for (int i = 0; i < CHANNELS; i++) begin
            if (is_chan(readback_select, i)) begin
                word = {4'(`ADDR_CH1 + i), failsafe_active, sums, 1'b0, ch_q[i]};
            end
        end
        unique case (readback_select)
            `ADDR_CHIP: word = {`ADDR_CHIP, failsafe_active, sums, 3'h0, tm_q,
                                ov_q, uv_q, serial_fail_flag_q, limp_input_level};
            `ADDR_PINS: word = {`ADDR_PINS, failsafe_active, 1'b0, |input_toggle,
                                control_input_level, load_pin_high};
            `ADDR_IDENT: word = {`ADDR_IDENT, failsafe_active, 3'h0,
                                 uv_q ? 8'h00 : PART_CODE};
            default: ;
        endcase
        word[`FM_POS] = failsafe_active;
    end

    // Frame sequencer and shift registers
    fault_readback_pkg::frame_state_t st_q, st_d;
    logic [15:0] tx_q, tx_d, rx_q, rx_d;
    logic [4:0] cnt_q, cnt_d;
    logic [3:0] sent_sel_d;
    logic so_d, oe_d;
    always_comb begin
        st_d = st_q;
        tx_d = tx_q;
        rx_d = rx_q;
        cnt_d = cnt_q;
        sent_sel_d = sent_sel_q;
        so_d = spi_so;
        oe_d = spi_so_oe;
        unique case (st_q)
            fault_readback_pkg::FR_IDLE: begin
                if (cs_fall) begin
                    st_d = fault_readback_pkg::FR_SHIFT;
                    tx_d = word;
                    so_d = word[15];
                    oe_d = 1'b1;
                    cnt_d = 5'h00;
                    sent_sel_d = readback_select;
                end
            end
            fault_readback_pkg::FR_SHIFT: begin
                if (cs_rise) begin
                    st_d = fault_readback_pkg::FR_DONE;
                    oe_d = 1'b0;
                end else begin
                    if (sclk_rise) begin
                        rx_d = {rx_q[14:0], s2_q[0]};
                        cnt_d = (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
                    end
                    if (sclk_fall) begin
                        tx_d = {tx_q[14:0], 1'b0};
                        so_d = tx_q[14];
                    end
                end
            end
            fault_readback_pkg::FR_DONE: begin
                st_d = fault_readback_pkg::FR_IDLE;
            end
            default: begin
                st_d = fault_readback_pkg::FR_IDLE; // Unused code recovers to idle
            end
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= fault_readback_pkg::FR_IDLE;
            tx_q <= 16'h0000;
            rx_q <= 16'h0000;
            cnt_q <= 5'h00;
            sent_sel_q <= `SEL_DEFAULT;
            spi_so <= 1'b0;
            spi_so_oe <= 1'b0;
        end else begin
            st_q <= st_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            cnt_q <= cnt_d;
            sent_sel_q <= sent_sel_d;
            spi_so <= so_d;
            spi_so_oe <= oe_d;
        end
    end

    // End-of-frame effects: clear on read and selector update
    logic init_write;
    assign frame_ok = (st_q == fault_readback_pkg::FR_DONE) && (cnt_q == `FRAME_BITS);
    assign frame_bad = (st_q == fault_readback_pkg::FR_DONE) && (cnt_q != `FRAME_BITS);
    assign init_write = frame_ok && (rx_q[`SI_ADDR_MSB:`SI_ADDR_LSB] == `ADDR_INIT);
    assign chip_clr = frame_ok && (sent_sel_q == `ADDR_CHIP);
    for (genvar i = 0; i < CHANNELS; i++) begin : g_clr
        assign chan_clr[i] = frame_ok && is_chan(sent_sel_q, i);
    end

    logic [3:0] sel_d;
    logic persist_d;
    always_comb begin
        sel_d = readback_select;
        persist_d = readback_persist_sel;
        if (init_write) begin
            sel_d = rx_q[`SI_SEL_MSB:`SI_SEL_LSB];
            persist_d = rx_q[`SI_PERSIST_POS];
        end else if (frame_ok && !readback_persist_sel) begin
            sel_d = `SEL_DEFAULT;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readback_select <= `SEL_DEFAULT;
            readback_persist_sel <= `PERSIST_RESET;
        end else begin
            readback_select <= sel_d;
            readback_persist_sel <= persist_d;
        end
    end

    // Checks on the readback behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    oneshot_revert_a: assert property (frame_ok && !init_write && !readback_persist_sel
        |=> readback_select == 4'h0) else $error("one-shot selector kept");
    persist_hold_a: assert property (frame_ok && !init_write && readback_persist_sel
        |=> $stable(readback_select)) else $error("persistent selector lost");
    fail_bit_a: assert property (st_q == fault_readback_pkg::FR_IDLE && cs_fall
        |=> tx_q[11] == $past(failsafe_active)) else $error("fail bit wrong");
    quick_addr_a: assert property (st_q == fault_readback_pkg::FR_IDLE && cs_fall
        && readback_select == 4'h0 |=> tx_q[15:12] == 4'h1) else $error("quick address");
    ident_zero_a: assert property (st_q == fault_readback_pkg::FR_IDLE && cs_fall
        && readback_select == 4'h9 && uv_q |=> tx_q[7:0] == 8'h00) else $error("id not zero");
    oc_overwrite_a: assert property (overcurrent_event[1]
        |=> ch_q[1][4:2] == $past(overcurrent_code[5:3])) else $error("oc code stale");
    set_wins_a: assert property (chan_clr[0] && open_load_off_flag[0]
        |=> ch_q[0][0]) else $error("open-load event lost");
    read_clears_a: assert property (chan_clr[0] && !open_load_on_flag[0] && !open_load_off_flag[0]
        |=> ch_q[0][1:0] == 2'h0) else $error("open-load not cleared");
    overload_sum_a: assert property (ch_q[1][6] |-> overload_summary)
        else $error("overload summary missing");
    msb_first_a: assert property (st_q == fault_readback_pkg::FR_SHIFT && sclk_fall && !cs_rise
        |=> spi_so == $past(tx_q[14])) else $error("shift order");

    oneshot_c: cover property (init_write && !rx_q[4] ##[1:1000] frame_ok);
    persist_c: cover property (init_write && rx_q[4] ##[1:1000] frame_ok ##[1:1000] frame_ok);
    chan_read_c: cover property (ch_q[2] != 7'h00 ##[1:1000] chan_clr[2]);

endmodule
`default_nettype wire

//--- tb/spi_host_model.sv
// Behavioural serial host that runs mode 0 frames against the readback bank
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
    parameter int HALF = 25
) (
    // Clock
    input wire logic clk,
    // Serial port
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_si,
    input wire logic spi_so,
    input wire logic spi_so_oe
);
    // Idle pins: clock parked low, frame select high
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end
    // One frame of nbits, MSB first; reply taken at each rising serial edge
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx, output logic oe);
        rx = 16'h0000;
        @(negedge clk);
        spi_cs_n = 1'b0;
        repeat (8) @(negedge clk);
        oe = spi_so_oe;
        for (int i = 15; i > 15 - nbits; i--) begin
            spi_si = tx[i];
            repeat (HALF) @(negedge clk);
            spi_clk = 1'b1;
            rx = {rx[14:0], spi_so};
            repeat (HALF) @(negedge clk);
            spi_clk = 1'b0;
        end
        repeat (HALF) @(negedge clk);
        spi_cs_n = 1'b1;
        spi_si = ~spi_si; // Released data line does not keep the last bit
        repeat (12) @(negedge clk);
    endtask
endmodule
`default_nettype wire

//--- tb/tb_spi_fault_status_readback.sv
// Self-checking bench for the serial status readback bank
`timescale 1ns/1ps
`default_nettype none
module tb_spi_fault_status_readback;
    logic clk, rst_n, spi_clk, spi_cs_n, spi_si, spi_so, spi_so_oe, oe;
    logic [4:0] overheat_shutdown, overheat_warning, overcurrent_event, open_load_on_flag, open_load_off_flag;
    logic [4:0] load_pin_high;
    logic [14:0] overcurrent_code;
    logic pump_fault, pwm_clock_fault, supply_low_flag, supply_high_flag, factory_test_flag, serial_fail_flag;
    logic failsafe_active, limp_input_level, readback_persist_sel;
    logic [3:0] control_input_level, input_toggle, readback_select;
    logic [15:0] rx;
    int fail_count = 0;
    int num_checks = 0;

    spi_fault_status_readback #(.CHANNELS(5), .PART_CODE(8'h3C)) uut ( // Part code is arbitrary
        .clk(clk), .rst_n(rst_n), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
        .spi_so_oe(spi_so_oe), .overheat_shutdown(overheat_shutdown), .overheat_warning(overheat_warning),
        .overcurrent_event(overcurrent_event), .overcurrent_code(overcurrent_code),
        .open_load_on_flag(open_load_on_flag), .open_load_off_flag(open_load_off_flag),
        .pump_fault(pump_fault), .pwm_clock_fault(pwm_clock_fault), .supply_low_flag(supply_low_flag),
        .supply_high_flag(supply_high_flag), .factory_test_flag(factory_test_flag),
        .serial_fail_flag(serial_fail_flag), .failsafe_active(failsafe_active),
        .limp_input_level(limp_input_level), .control_input_level(control_input_level),
        .input_toggle(input_toggle), .load_pin_high(load_pin_high), .readback_select(readback_select),
        .readback_persist_sel(readback_persist_sel));
    spi_host_model #(.HALF(25)) host (.clk(clk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
        .spi_so(spi_so), .spi_so_oe(spi_so_oe));

    // Clock and time-zero inputs
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        {overheat_shutdown, overheat_warning, overcurrent_event, open_load_on_flag, open_load_off_flag} = '0;
        {load_pin_high, overcurrent_code, control_input_level, input_toggle} = '0;
        {pump_fault, pwm_clock_fault, supply_low_flag, supply_high_flag, factory_test_flag} = '0;
        {serial_fail_flag, failsafe_active, limp_input_level} = '0;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    // Full frame with the reply and the enable judged
    task automatic rd(input logic [15:0] tx, input logic [15:0] exp);
        host.xfer(tx, 16, rx, oe);
        check(rx, exp);
        check({15'h0, oe}, 16'h0001);
    endtask
    task automatic oc(input logic [2:0] c);
        @(negedge clk);
        overcurrent_code = {9'h0, c, 3'h0};
        overcurrent_event = 5'h02;
        @(negedge clk);
        overcurrent_event = 5'h00;
    endtask

    task automatic t_reset_oneshot();
        check({11'h0, readback_persist_sel, readback_select}, 16'h0000);
        check({15'h0, spi_so_oe}, 16'h0000);
        limp_input_level = 1'b1;
        rd(16'hF000, 16'h1440);
        rd(16'h0007, 16'h1440);
        rd(16'hF000, 16'h7401);
        rd(16'hF000, 16'h1000);
    endtask
    task automatic t_channel();
        @(negedge clk);
        {overheat_shutdown, overheat_warning, open_load_on_flag, open_load_off_flag} = {4{5'h02}};
        @(negedge clk);
        {overheat_shutdown, overheat_warning, open_load_on_flag, open_load_off_flag} = '0;
        oc(3'h5);
        oc(3'h6);
        rd(16'h0013, 16'h1302);
        rd(16'hF000, 16'h337B);
        check({11'h0, readback_persist_sel, readback_select}, 16'h0013);
        rd(16'hF000, 16'h3000);
        for (int c = 1; c < 7; c++) begin
            oc(c[2:0]);
            rd(16'hF000, 16'h3200 | 16'(c << 2));
        end
        // First and fifth channel; an open-load event held across the clearing read
        @(negedge clk);
        overcurrent_code = {3'h3, 12'h000};
        overcurrent_event = 5'h10;
        open_load_off_flag = 5'h01;
        @(negedge clk);
        overcurrent_event = 5'h00;
        rd(16'h0012, 16'h3300);
        rd(16'hF000, 16'h2301);
        open_load_off_flag = 5'h00;
        rd(16'hF000, 16'h2301);
        rd(16'h0016, 16'h2200);
        rd(16'h0013, 16'h620C);
    endtask
    task automatic t_ident();
        failsafe_active = 1'b1;
        limp_input_level = 1'b0;
        @(negedge clk);
        {supply_low_flag, factory_test_flag} = 2'b11;
        @(negedge clk);
        {supply_low_flag, factory_test_flag} = 2'b00;
        rd(16'h0019, 16'h3C00);
        rd(16'hF000, 16'h9800);
        rd(16'h0017, 16'h9800);
        rd(16'hF000, 16'h7C14);
        rd(16'h0019, 16'h7800);
        rd(16'hF000, 16'h983C);
        do_reset();
        rd(16'hF000, 16'h1C40);
    endtask
    task automatic t_pins_refuse();
        failsafe_active = 1'b0;
        {control_input_level, input_toggle, load_pin_high} = {4'hA, 4'h1, 5'h15};
        rd(16'h0018, 16'h1440);
        rd(16'hF000, 16'h8355);
        {control_input_level, input_toggle, load_pin_high} = {4'h5, 4'h0, 5'h0A};
        rd(16'hF000, 16'h80AA);
        host.xfer(16'hF000, 8, rx, oe);
        @(negedge clk);
        {supply_high_flag, pump_fault, pwm_clock_fault} = 3'b111;
        @(negedge clk);
        {supply_high_flag, pump_fault, pwm_clock_fault} = 3'b000;
        rd(16'h0011, 16'h80AA);
        rd(16'hF000, 16'h14E0);
        rd(16'h0017, 16'h14E0);
        rd(16'hF000, 16'h740A);
        rd(16'hF000, 16'h7000);
    endtask

    // Main sequence
    initial begin
        do_reset();
        t_reset_oneshot();
        t_channel();
        t_ident();
        t_pins_refuse();
        conclude();
    end
    // Watchdog
    initial begin
        #200us;
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire
